// ### testbench.sv
`timescale 1ns/10ps
// Programs the engine through its registers and plays the incoming link side.
module testbench;
	localparam int unsigned LIM = 200;
	logic clk_in = 0, reset_in = 1, en_in = 1, reg_wr_in = 0, reg_rd_in = 0, reg_ack_out;
	logic load_busy_in = 1, quasi_reset_out, load_late_out, part_active_in = 0;
	logic port_migrate_in = 0, link_reset_out, tx_valid_out, tx_accept_in, tx_cpl_in;
	logic tx_cpl_ok_in, rx_valid_in = 0, rx_cpl_out, gas_req_out, gas_wr_out, gas_ack_in;
	logic ok_sel = 1, seen_wr;
	logic [2:0] dly = 3'h0;
	logic [19:0] reg_addr_in = 20'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rx_cpl_data_out, gas_addr_out;
	logic [31:0] gas_wdata_out, gas_rdata_in, seen_addr, seen_wdata, rd;
	xcre_pkg::xcre_req_s tx_req_out, rx_req_in = '0, e;
	int n_fail = 0, num_checks = 0, cyc = 0;
	xcre_top #(.LOAD_LIMIT_CYC(LIM)) xcre_top_i (.*);
	xcre_peer xcre_peer_i (.clk_in(clk_in), .ok_in(ok_sel), .dly_in(dly), .valid_in(tx_valid_out),
		.accept_out(tx_accept_in), .cpl_out(tx_cpl_in), .cpl_ok_out(tx_cpl_ok_in),
		.greq_in(gas_req_out), .gwr_in(gas_wr_out), .gaddr_in(gas_addr_out),
		.gwdata_in(gas_wdata_out), .grdata_out(gas_rdata_in), .gack_out(gas_ack_in),
		.seen_wr_out(seen_wr), .seen_addr_out(seen_addr), .seen_wdata_out(seen_wdata));
	always #25 clk_in = ~clk_in;
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One register access; the strobe stays up for exactly one sampling edge.
	task automatic acc(input logic wr, input logic [19:0] a, input logic [31:0] d);
		@(negedge clk_in);
		reg_wr_in = wr;
		reg_rd_in = ~wr;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(negedge clk_in);
		chk({31'h0, reg_ack_out}, 32'h1, "ack");
		rd = reg_rdata_out;
		reg_wr_in = 0;
		reg_rd_in = 0;
	endtask
	// Incoming request, held until its completion pulse is seen.
	task automatic rx(input logic [9:0] ra, input logic w, input logic [31:0] d);
		@(negedge clk_in);
		rx_req_in = '{16'h0004, 16'h0000, ra, 1'b0, w, d};
		rx_valid_in = 1;
		for (int k = 0; k < 20 && rx_cpl_out !== 1'b1; k++) @(negedge clk_in);
		chk({31'h0, rx_cpl_out}, 32'h1, "rx completion");
		rd = rx_cpl_data_out;
		rx_valid_in = 0;
		rx_req_in = ~rx_req_in;
	endtask
	// Program, launch, check the request on the link, then wait for the outcome.
	task automatic xfer(input logic [31:0] t, o, d, input logic ok, input logic [2:0] w);
		ok_sel = ok;
		dly = w;
		acc(1, 20'h11510, t);
		acc(1, 20'h11514, o);
		acc(1, 20'h11518, d);
		@(negedge clk_in);
		e = '{16'h0004, t[31:16], {t[11:8], t[7:2]}, o[0], o[1], d};
		chk({31'h0, tx_valid_out}, 32'h1, "launch");
		num_checks++;
		if (tx_req_out !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: request %h", $time, tx_req_out);
		end
		for (int k = 0; k < 20; k++)
		begin
			acc(0, 20'h1151C, 32'h0);
			if (rd[1:0] != 2'b00)
				break;
		end
		chk(rd, ok ? 32'h1 : 32'h2, "status");
	endtask
	// A hang costs a mismatch and still reaches the verdict.
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (20) @(negedge clk_in);
		reset_in = 0;
		chk({31'h0, quasi_reset_out}, 32'h1, "quasi held");
		acc(0, 20'h1151C, 32'h0);
		chk(rd, 32'h0, "status idle");
		xfer(32'h0000_0FF8, 32'h2, 32'h0003_E100, 1, 3'h0);
		xfer(32'h5AD3_0ABC, 32'h1, 32'h1234_5678, 0, 3'h4);
		$display("crosslink launch test done");
		load_busy_in = 0;
		repeat (2) @(negedge clk_in);
		chk({31'h0, quasi_reset_out}, 32'h0, "quasi released");
		chk({31'h0, load_late_out}, 32'h0, "late early");
		rx(10'h3FE, 1, 32'h0003_E100);
		acc(0, 20'h11FF8, 32'h0);
		chk(rd, 32'h0003_E100, "pointer");
		rx(10'h3FF, 1, 32'h0000_00C3);
		chk({seen_wr, seen_addr[30:0]}, 32'h8003_E100, "indirect write address");
		chk(seen_wdata, 32'h0000_00C3, "indirect write data");
		rx(10'h3FF, 0, 32'h0);
		chk(rd, 32'hA5A6_E100, "indirect read");
		acc(0, 20'h11600, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("indirect access test done");
		part_active_in = 1;
		port_migrate_in = 1;
		repeat (2) @(negedge clk_in);
		chk({31'h0, link_reset_out}, 32'h0, "link kept");
		part_active_in = 0;
		repeat (2) @(negedge clk_in);
		chk({31'h0, link_reset_out}, 32'h1, "link reset");
		port_migrate_in = 0;
		reset_in = 1;
		load_busy_in = 1;
		repeat (2) @(negedge clk_in);
		reset_in = 0;
		repeat (LIM + 5) @(negedge clk_in);
		chk({31'h0, load_late_out}, 32'h1, "late flag");
		$display("migration and deadline test done");
		give_verdict();
	end
endmodule

// ### xcre_cfg.svh
`ifndef XCRE_CFG_SVH
`define XCRE_CFG_SVH
// Register offsets within the non-transparent function space (byte addresses).
`define XCRE_OFS_TARGET 12'h510
`define XCRE_OFS_OPER 12'h514
`define XCRE_OFS_WDATA 12'h518
`define XCRE_OFS_STATUS 12'h51C
`define XCRE_OFS_IND_ADDR 12'hFF8
`define XCRE_OFS_IND_DATA 12'hFFC
// Global space base of this function; the target register then sits at base plus offset.
`define XCRE_FN_BASE 20'h11000
// Target control field positions.
`define XCRE_TGT_BUS_HI 31
`define XCRE_TGT_BUS_LO 24
`define XCRE_TGT_SLOT_HI 23
`define XCRE_TGT_SLOT_LO 19
`define XCRE_TGT_FN_HI 18
`define XCRE_TGT_FN_LO 16
`define XCRE_TGT_UIDX_HI 11
`define XCRE_TGT_UIDX_LO 8
`define XCRE_TGT_DIDX_HI 7
`define XCRE_TGT_DIDX_LO 2
// Operation control field positions.
`define XCRE_OP_TYPE_BIT 0
`define XCRE_OP_SEL_BIT 1
`define XCRE_OP_TYPE0 1'h0
`define XCRE_OP_WRITE 1'h1
// Status bit positions.
`define XCRE_STS_DONE_BIT 0
`define XCRE_STS_ERR_BIT 1
`define XCRE_STS_BUSY_BIT 2
// Requester identity reserved for crosslink configuration requests.
`define XCRE_REQ_ID 16'h0004
// Address of the indirect pair as seen on a received request.
`define XCRE_RX_IND_ADDR 10'h3FE
`define XCRE_RX_IND_DATA 10'h3FF
// Deadline for the load after fundamental reset.
`define XCRE_LOAD_LIMIT_NS 1000000000
`define XCRE_CLK_NS 50
`define XCRE_LOAD_LIMIT_CYC (`XCRE_LOAD_LIMIT_NS / `XCRE_CLK_NS)
`define XCRE_ZERO32 32'h0000_0000
`endif

// ### xcre_gas_if.sv
`timescale 1ns/10ps
interface xcre_gas_if;
	logic req;
	logic wr;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	modport master (output req, output wr, output addr, output wdata, input rdata, input ack);
	modport slave (input req, input wr, input addr, input wdata, output rdata, output ack);
endinterface

// ### xcre_gas_port.sv
`timescale 1ns/10ps
`include "xcre_cfg.svh"
// Indirect window into the global address space, addressed by a held pointer.
module xcre_gas_port (
	input wire logic clk_in, // Core clock.
	input wire logic reset_in, // Synchronous reset.
	input wire logic en_in, // Clock enable.
	input wire logic ptr_wr_in, // Load the pointer.
	input wire logic data_rd_in, // Read through the pointer.
	input wire logic data_wr_in, // Write through the pointer.
	input wire logic [31:0] wdata_in, // Write value.
	output logic [31:0] ptr_out, // Held pointer.
	output logic [31:0] rdata_out, // Registered read data.
	output logic done_out, // Access finished.
	xcre_gas_if.master gas // Global space bus.
);
	logic pend_q;
	// Pointer register; its value selects the global register for every data access.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			ptr_out <= `XCRE_ZERO32;
		else if (en_in && ptr_wr_in)
			ptr_out <= wdata_in;
	end
	// Start one global access per data strobe and hold it until acknowledged.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			pend_q <= 1'b0;
			gas.req <= 1'b0;
			gas.wr <= 1'b0;
			gas.addr <= `XCRE_ZERO32;
			gas.wdata <= `XCRE_ZERO32;
			rdata_out <= `XCRE_ZERO32;
			done_out <= 1'b0;
		end
		else if (en_in)
		begin
			done_out <= 1'b0;
			if (!pend_q && (data_rd_in || data_wr_in))
			begin
				pend_q <= 1'b1;
				gas.req <= 1'b1;
				gas.wr <= data_wr_in;
				gas.addr <= ptr_out;
				gas.wdata <= wdata_in;
			end
			else if (pend_q && gas.ack)
			begin
				pend_q <= 1'b0;
				gas.req <= 1'b0;
				rdata_out <= gas.rdata;
				done_out <= 1'b1;
			end
		end
	end
endmodule

// ### xcre_link_tx.sv
`timescale 1ns/10ps
// Holds one outgoing request on the crosslink until the peer accepts and completes it.
module xcre_link_tx (
	input wire logic clk_in, // Core clock.
	input wire logic reset_in, // Synchronous reset.
	input wire logic en_in, // Clock enable.
	input wire logic start_in, // Launch a request.
	input wire xcre_pkg::xcre_req_s req_in, // Request contents.
	input wire logic accept_in, // Peer took the request.
	input wire logic cpl_in, // Completion seen.
	input wire logic cpl_ok_in, // Completion successful.
	output logic valid_out, // Request valid on link.
	output xcre_pkg::xcre_req_s req_out, // Request on link.
	output logic fin_out, // Transfer finished pulse.
	output logic ok_out // Finished without error.
);
	xcre_pkg::xcre_state_e state_q;
	// Request sequencing: send, then wait for the completion.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_q <= xcre_pkg::XCRE_IDLE;
			valid_out <= 1'b0;
			req_out <= '0;
			fin_out <= 1'b0;
			ok_out <= 1'b0;
		end
		else if (en_in)
		begin
			fin_out <= 1'b0;
			case (state_q)
				xcre_pkg::XCRE_IDLE:
					if (start_in)
					begin
						req_out <= req_in;
						valid_out <= 1'b1;
						state_q <= xcre_pkg::XCRE_SEND;
					end
				xcre_pkg::XCRE_SEND:
					if (accept_in)
					begin
						valid_out <= 1'b0;
						state_q <= xcre_pkg::XCRE_WAIT;
					end
				xcre_pkg::XCRE_WAIT:
					if (cpl_in)
					begin
						fin_out <= 1'b1;
						ok_out <= cpl_ok_in;
						state_q <= xcre_pkg::XCRE_IDLE;
					end
				default:
					state_q <= xcre_pkg::XCRE_IDLE;
			endcase
		end
	end
endmodule

// ### xcre_peer.sv
`timescale 1ns/10ps
// Far switch port and its global space; both answer on the falling edge.
module xcre_peer (
	input wire logic clk_in, // Clock.
	input wire logic ok_in, // Status to return.
	input wire logic [2:0] dly_in, // Cycles before accept.
	input wire logic valid_in, // Request valid.
	output logic accept_out, // Request taken.
	output logic cpl_out, // Completion pulse.
	output logic cpl_ok_out, // Completion status.
	input wire logic greq_in, // Global request.
	input wire logic gwr_in, // Global write.
	input wire logic [31:0] gaddr_in, // Global address.
	input wire logic [31:0] gwdata_in, // Global write data.
	output logic [31:0] grdata_out, // Global read data.
	output logic gack_out, // Global acknowledge.
	output logic seen_wr_out, // Last write flag.
	output logic [31:0] seen_addr_out, // Last address.
	output logic [31:0] seen_wdata_out // Last write data.
);
	logic [2:0] cnt = 3'h0;
	logic busy = 1'b0;
	logic gwait = 1'b0;
	// Outputs toward the engine start defined so it never sees an unknown answer; the seen_* outputs do not.
	initial
	begin
		accept_out = 1'b0;
		cpl_out = 1'b0;
		cpl_ok_out = 1'b0;
		gack_out = 1'b0;
		grdata_out = 32'h0;
	end
	// Accept after the set delay, complete four cycles later; status is junk between.
	always @(negedge clk_in)
	begin
		accept_out <= 1'b0;
		cpl_out <= 1'b0;
		cpl_ok_out <= ~ok_in;
		cnt <= cnt + 3'h1;
		if (!busy && !(valid_in && !accept_out))
			cnt <= 3'h0;
		if (!busy && valid_in && !accept_out && cnt == dly_in)
		begin
			accept_out <= 1'b1;
			busy <= 1'b1;
			cnt <= 3'h0;
		end
		if (busy && cnt == 3'h3)
		begin
			cpl_out <= 1'b1;
			cpl_ok_out <= ok_in;
			busy <= 1'b0;
			cnt <= 3'h0;
		end
	end
	// Acknowledge in the second request cycle; read data toggles when not valid.
	always @(negedge clk_in)
	begin
		gack_out <= 1'b0;
		grdata_out <= ~grdata_out;
		gwait <= greq_in && !gack_out;
		if (greq_in && gwait && !gack_out)
		begin
			gack_out <= 1'b1;
			grdata_out <= gaddr_in ^ 32'hA5A5_0000;
			seen_wr_out <= gwr_in;
			seen_addr_out <= gaddr_in;
			seen_wdata_out <= gwdata_in;
		end
	end
endmodule

// ### xcre_pkg.sv
package xcre_pkg;
	typedef enum logic [1:0] {XCRE_IDLE, XCRE_SEND, XCRE_WAIT} xcre_state_e;
	typedef struct packed {
		logic [15:0] req_id;
		logic [15:0] cpl_id;
		logic [9:0] reg_addr;
		logic type1;
		logic write;
		logic [31:0] data;
	} xcre_req_s;
endpackage

// ### xcre_sva.sv
`timescale 1ns/10ps
// Ties the outgoing request and the status outputs to what was programmed at the ports.
module xcre_sva #(
	parameter int unsigned LOAD_LIMIT_CYC = 100 // Load deadline in cycles.
) (
	input wire logic clk_in, // Clock.
	input wire logic reset_in, // Reset.
	input wire logic en_in, // Enable.
	input wire logic reg_wr_in, // Write strobe.
	input wire logic [19:0] reg_addr_in, // Address.
	input wire logic [31:0] reg_wdata_in, // Write data.
	input wire logic load_busy_in, // Load running.
	input wire logic quasi_reset_out, // Quasi-reset.
	input wire logic load_late_out, // Late flag.
	input wire logic part_active_in, // Active.
	input wire logic port_migrate_in, // Migration.
	input wire logic link_reset_out, // Link reset.
	input wire logic tx_valid_out, // Request valid.
	input wire xcre_pkg::xcre_req_s tx_req_out, // Request.
	input wire logic rx_valid_in, // Incoming valid.
	input wire xcre_pkg::xcre_req_s rx_req_in, // Incoming request.
	input wire logic rx_cpl_out, // Incoming done.
	input wire logic gas_req_out, // Global request.
	input wire logic [31:0] gas_addr_out // Global address.
);
	logic [31:0] tgt_q;
	logic [31:0] oper_q;
	logic [31:0] ptr_q;
	int unsigned cnt_q;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Shadows of target and operation, so each request field has a known source.
	always_ff @(posedge clk_in)
	begin
		if (en_in && reg_wr_in && reg_addr_in == 20'h11510)
			tgt_q <= reg_wdata_in;
		if (en_in && reg_wr_in && reg_addr_in == 20'h11514)
			oper_q <= reg_wdata_in;
	end
	// Shadow pointer, loaded at the edge that takes a type 0 write to function 0 at its address.
	// Waiting for the completion instead would miss it, as the request is gone by then.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			ptr_q <= 32'h0;
		else if (en_in && rx_valid_in && !rx_req_in.type1 && rx_req_in.cpl_id[2:0] == 3'h0
			&& rx_req_in.reg_addr == 10'h3FE && rx_req_in.write)
			ptr_q <= rx_req_in.data;
	end
	// Busy cycles since reset; the check stops one short of the limit so the flag's own latency is safe.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			cnt_q <= 32'h0;
		else if (en_in && load_busy_in)
			cnt_q <= cnt_q + 32'h1;
	end
	req_ident_a: assert property (tx_valid_out |-> tx_req_out.req_id == 16'h0004)
		else $error("requester identity wrong");
	cpl_ident_a: assert property (tx_valid_out |-> tx_req_out.cpl_id == tgt_q[31:16])
		else $error("completer identity wrong");
	reg_index_a: assert property (tx_valid_out |-> tx_req_out.reg_addr == {tgt_q[11:8], tgt_q[7:2]})
		else $error("register address wrong");
	req_kind_a: assert property (tx_valid_out |-> {tx_req_out.write, tx_req_out.type1} == oper_q[1:0])
		else $error("request kind wrong");
	launch_src_a: assert property ($rose(tx_valid_out) |-> $past(reg_wr_in && reg_addr_in == 20'h11518, 2) && tx_req_out.data == $past(reg_wdata_in, 2))
		else $error("launch without data write");
	ptr_use_a: assert property (gas_req_out |-> gas_addr_out == ptr_q)
		else $error("global access off pointer");
	quasi_follow_a: assert property (en_in |=> quasi_reset_out == $past(load_busy_in))
		else $error("quasi-reset not following load");
	late_early_a: assert property (cnt_q < LOAD_LIMIT_CYC - 1 |-> !load_late_out)
		else $error("late flag too early");
	link_keep_a: assert property (en_in && part_active_in && port_migrate_in |=> !link_reset_out)
		else $error("link reset in active partition");
	cover property ($rose(tx_valid_out));
	cover property (rx_cpl_out && $past(rx_valid_in && rx_req_in.reg_addr == 10'h3FF));
	cover property ($rose(load_late_out));
endmodule
bind xcre_top xcre_sva #(.LOAD_LIMIT_CYC(LOAD_LIMIT_CYC)) xcre_sva_i (.*);

// ### xcre_top.sv
`timescale 1ns/10ps
`include "xcre_cfg.svh"
// Functional notes
// - Completer bus, slot, function come from the target control fields.
// - Request register address is upper index joined with dword index.
// - Access type zero issues a type 0 configuration request.
// - Operation select one issues a configuration write.
// - Writing write-data launches the programmed request across the crosslink.
// - Every request carries requester identity bus 0, device 0, function 4.
// - Done bit sets once the transfer finishes successfully.
// - Received type 0 write to function 0 at 0xFF8 loads indirect address.
// - Indirect data accesses the global register the indirect address selects.
// - Target control at 0x510; global address is function base plus offset.
// - Quasi-reset holds while the EEPROM load runs, released at its end.
// - The load including remote configuration completes within one second.
// - Migrating a port into an active partition never resets its link.
module xcre_top #(
	parameter int unsigned LOAD_LIMIT_CYC = `XCRE_LOAD_LIMIT_CYC // Load deadline in cycles.
) (
	input wire logic clk_in, // Core clock, 20 MHz.
	input wire logic reset_in, // Fundamental reset, synchronous.
	input wire logic en_in, // Clock enable.
	input wire logic reg_wr_in, // Local register write strobe.
	input wire logic reg_rd_in, // Local register read strobe.
	input wire logic [19:0] reg_addr_in, // Local global-space byte address.
	input wire logic [31:0] reg_wdata_in, // Local write data.
	output logic [31:0] reg_rdata_out, // Local read data.
	output logic reg_ack_out, // Local access done.
	input wire logic load_busy_in, // EEPROM load running.
	output logic quasi_reset_out, // Switch held in quasi-reset.
	output logic load_late_out, // Load overran its deadline.
	input wire logic part_active_in, // Target partition is active.
	input wire logic port_migrate_in, // Port being migrated.
	output logic link_reset_out, // Reset request to migrating port link.
	output logic tx_valid_out, // Outgoing request valid.
	output xcre_pkg::xcre_req_s tx_req_out, // Outgoing request.
	input wire logic tx_accept_in, // Peer accepted request.
	input wire logic tx_cpl_in, // Completion arrived.
	input wire logic tx_cpl_ok_in, // Completion status ok.
	input wire logic rx_valid_in, // Incoming request valid.
	input wire xcre_pkg::xcre_req_s rx_req_in, // Incoming request.
	output logic rx_cpl_out, // Incoming request completed.
	output logic [31:0] rx_cpl_data_out, // Completion data.
	output logic gas_req_out, // Global space request.
	output logic gas_wr_out, // Global space write.
	output logic [31:0] gas_addr_out, // Global space address.
	output logic [31:0] gas_wdata_out, // Global space write data.
	input wire logic [31:0] gas_rdata_in, // Global space read data.
	input wire logic gas_ack_in // Global space acknowledge.
);
	logic [31:0] target_q;
	logic [31:0] oper_q;
	logic [31:0] wdata_q;
	logic done_q;
	logic err_q;
	logic launch_q;
	logic rx_busy_q;
	logic [31:0] load_cnt_q;
	logic local_pend_q;
	logic [31:0] ind_ptr;
	logic [31:0] ind_rdata;
	logic ind_done;
	logic ptr_wr;
	logic data_rd;
	logic data_wr;
	logic [31:0] ind_wdata;
	logic tx_fin;
	logic tx_ok;
	logic tx_valid;
	xcre_pkg::xcre_req_s tx_req;
	xcre_pkg::xcre_req_s launch_req;
	xcre_gas_if gas_bus ();

	// Check whether a byte address in global space hits the given local register offset.
	function automatic logic hit(input logic [19:0] a, input logic [11:0] ofs);
		hit = (a == (`XCRE_FN_BASE + {8'h00, ofs}));
	endfunction

	// Received requests are only ours when they are type 0 to function 0.
	function automatic logic rx_hit(input xcre_pkg::xcre_req_s r, input logic [9:0] a);
		rx_hit = !r.type1 && (r.cpl_id[2:0] == 3'h0) && (r.reg_addr == a);
	endfunction

	// Build the outgoing request from the programmed registers.
	always_comb
	begin
		launch_req.req_id = `XCRE_REQ_ID;
		launch_req.cpl_id = {target_q[`XCRE_TGT_BUS_HI:`XCRE_TGT_BUS_LO],
			target_q[`XCRE_TGT_SLOT_HI:`XCRE_TGT_SLOT_LO],
			target_q[`XCRE_TGT_FN_HI:`XCRE_TGT_FN_LO]};
		launch_req.reg_addr = {target_q[`XCRE_TGT_UIDX_HI:`XCRE_TGT_UIDX_LO],
			target_q[`XCRE_TGT_DIDX_HI:`XCRE_TGT_DIDX_LO]};
		launch_req.type1 = (oper_q[`XCRE_OP_TYPE_BIT] != `XCRE_OP_TYPE0);
		launch_req.write = (oper_q[`XCRE_OP_SEL_BIT] == `XCRE_OP_WRITE);
		launch_req.data = wdata_q;
	end

	// Local register writes for the target, operation and data registers.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			target_q <= `XCRE_ZERO32;
			oper_q <= `XCRE_ZERO32;
			wdata_q <= `XCRE_ZERO32;
			launch_q <= 1'b0;
		end
		else if (en_in)
		begin
			launch_q <= 1'b0;
			if (reg_wr_in)
			begin
				if (hit(reg_addr_in, `XCRE_OFS_TARGET))
					target_q <= reg_wdata_in;
				else if (hit(reg_addr_in, `XCRE_OFS_OPER))
					oper_q <= reg_wdata_in;
				else if (hit(reg_addr_in, `XCRE_OFS_WDATA))
				begin
					wdata_q <= reg_wdata_in;
					launch_q <= 1'b1;
				end
			end
		end
	end

	// A launch clears done; a finish loads it from the completion status, and the finish wins if both coincide.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else if (en_in)
		begin
			if (tx_fin)
			begin
				done_q <= tx_ok;
				err_q <= !tx_ok;
			end
			else if (launch_q)
			begin
				done_q <= 1'b0;
				err_q <= 1'b0;
			end
		end
	end

	// Local reads; unmapped addresses return zero. The agent polls done here.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			reg_rdata_out <= `XCRE_ZERO32;
			reg_ack_out <= 1'b0;
		end
		else if (en_in)
		begin
			reg_ack_out <= reg_wr_in || reg_rd_in;
			if (reg_rd_in)
			begin
				if (hit(reg_addr_in, `XCRE_OFS_TARGET))
					reg_rdata_out <= target_q;
				else if (hit(reg_addr_in, `XCRE_OFS_OPER))
					reg_rdata_out <= oper_q;
				else if (hit(reg_addr_in, `XCRE_OFS_WDATA))
					reg_rdata_out <= wdata_q;
				else if (hit(reg_addr_in, `XCRE_OFS_STATUS))
					reg_rdata_out <= {29'h0000_0000, tx_valid, err_q, done_q};
				else if (hit(reg_addr_in, `XCRE_OFS_IND_ADDR))
					reg_rdata_out <= ind_ptr;
				else
					reg_rdata_out <= `XCRE_ZERO32;
			end
		end
	end

	// Received requests drive the indirect pair; the pointer takes a write at 0xFF8.
	always_comb
	begin
		ptr_wr = 1'b0;
		data_rd = 1'b0;
		data_wr = 1'b0;
		ind_wdata = rx_req_in.data;
		if (rx_valid_in && !rx_busy_q)
		begin
			if (rx_hit(rx_req_in, `XCRE_RX_IND_ADDR) && rx_req_in.write)
				ptr_wr = 1'b1;
			else if (rx_hit(rx_req_in, `XCRE_RX_IND_DATA))
			begin
				data_wr = rx_req_in.write;
				data_rd = !rx_req_in.write;
			end
		end
	end

	// Completion back toward the peer for each received request.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			rx_busy_q <= 1'b0;
			rx_cpl_out <= 1'b0;
			rx_cpl_data_out <= `XCRE_ZERO32;
		end
		else if (en_in)
		begin
			rx_cpl_out <= 1'b0;
			if (rx_busy_q && ind_done)
			begin
				rx_busy_q <= 1'b0;
				rx_cpl_out <= 1'b1;
				rx_cpl_data_out <= ind_rdata;
			end
			else if (data_rd || data_wr)
				rx_busy_q <= 1'b1;
			else if (rx_valid_in && !rx_busy_q)
			begin
				rx_cpl_out <= 1'b1;
				rx_cpl_data_out <= `XCRE_ZERO32;
			end
		end
	end

	// Quasi-reset follows the load; a deadline counter flags an overrun.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			quasi_reset_out <= 1'b1;
			load_late_out <= 1'b0;
			load_cnt_q <= `XCRE_ZERO32;
		end
		else if (en_in)
		begin
			quasi_reset_out <= load_busy_in;
			if (load_busy_in && load_cnt_q < LOAD_LIMIT_CYC)
				load_cnt_q <= load_cnt_q + 32'h0000_0001;
			else if (load_busy_in)
				load_late_out <= 1'b1;
		end
	end

	// Link reset is only requested when a port joins a partition not yet active.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			link_reset_out <= 1'b0;
		else if (en_in)
			link_reset_out <= port_migrate_in && !part_active_in;
	end

	// Global bus outputs already come from flip-flops inside the indirect port.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			local_pend_q <= 1'b0;
		else if (en_in)
			local_pend_q <= gas_bus.req;
	end
	assign gas_req_out = gas_bus.req;
	assign gas_wr_out = gas_bus.wr;
	assign gas_addr_out = gas_bus.addr;
	assign gas_wdata_out = gas_bus.wdata;
	assign gas_bus.rdata = gas_rdata_in;
	assign gas_bus.ack = gas_ack_in && local_pend_q;
	assign tx_valid_out = tx_valid;
	assign tx_req_out = tx_req;

	xcre_link_tx u_tx (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.en_in(en_in),
		.start_in(launch_q),
		.req_in(launch_req),
		.accept_in(tx_accept_in),
		.cpl_in(tx_cpl_in),
		.cpl_ok_in(tx_cpl_ok_in),
		.valid_out(tx_valid),
		.req_out(tx_req),
		.fin_out(tx_fin),
		.ok_out(tx_ok)
	);

	xcre_gas_port u_gas (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.en_in(en_in),
		.ptr_wr_in(ptr_wr),
		.data_rd_in(data_rd),
		.data_wr_in(data_wr),
		.wdata_in(ind_wdata),
		.ptr_out(ind_ptr),
		.rdata_out(ind_rdata),
		.done_out(ind_done),
		.gas(gas_bus)
	);
endmodule
